// *** rtl/lspt_align.v ***
// Purpose: picks sixteen of the seventeen conversion bits
// Assumes: flag sampled at measurement start by the caller
// Notes: purely combinational, caller registers the result
`include "lspt_map.vh"

module lspt_align (
	// Raw conversion
	input wire [`LSPT_CONV_W-1:0] conv_data,
	// High when the low sixteen bits are wanted
	input wire low_align,
	// Selected word
	output wire [`LSPT_RES_W-1:0] aligned_word
);

	// Set flag keeps the low bits, clear flag drops the lsb
	assign aligned_word = low_align ? conv_data[`LSPT_RES_W-1:0] : conv_data[`LSPT_CONV_W-1:1];

endmodule // lspt_align

// *** rtl/lspt_map.vh ***
// Purpose: constants of the light sensor parameter table
// Assumes: included by the table and its aligner only
// Notes: offsets are parameter indices, not bus addresses
`ifndef LSPT_MAP_VH
`define LSPT_MAP_VH

// Entry width and table size
`define LSPT_DW 8
`define LSPT_IW 5
`define LSPT_DEPTH 32

// Entry indices
`define LSPT_OFS_BUS_ADDR 5'h00
`define LSPT_OFS_CHAN_EN 5'h01
`define LSPT_OFS_LED_12 5'h02
`define LSPT_OFS_LED_3 5'h03
`define LSPT_OFS_PROX_ALIGN 5'h05
`define LSPT_OFS_AMB_ALIGN 5'h06
`define LSPT_OFS_LED_RECOVERY_TIME 5'h1C
`define LSPT_OFS_IR_COUNT 5'h1D
`define LSPT_OFS_IR_GAIN 5'h1E
`define LSPT_OFS_IR_MISC 5'h1F

// Writable bit masks, reserved bits held at zero
`define LSPT_MSK_BUS_ADDR 8'hFF
`define LSPT_MSK_CHAN_EN 8'hF7
`define LSPT_MSK_LED_12 8'h77
`define LSPT_MSK_LED_3 8'h07
`define LSPT_MSK_PROX_ALIGN 8'h70
`define LSPT_MSK_AMB_ALIGN 8'h30
`define LSPT_MSK_LED_RECOVERY_TIME 8'hFF
`define LSPT_MSK_IR_COUNT 8'h70
`define LSPT_MSK_IR_GAIN 8'hFF
`define LSPT_MSK_IR_MISC 8'h20
`define LSPT_MSK_NONE 8'h00

// Reset values
`define LSPT_RST_LED_12 8'h21
`define LSPT_RST_ZERO 8'h00
`define LSPT_BOOT_ADDR 8'h00

// Channel enable list bit positions
`define LSPT_EN_PROX1 0
`define LSPT_EN_PROX2 1
`define LSPT_EN_PROX3 2
`define LSPT_EN_VIS 4
`define LSPT_EN_IR 5
`define LSPT_EN_AUX 6
`define LSPT_UV_INDEX_ENABLE 7

// Alignment flag bit positions
`define LSPT_AL_PROX1 4
`define LSPT_AL_PROX2 5
`define LSPT_AL_PROX3 6
`define LSPT_AL_VIS 4
`define LSPT_AL_IR 5

// Driver mask fields
`define LSPT_LED_LO 2:0
`define LSPT_LED_HI 6:4
`define LSPT_LED_NONE 3'h0

// Measurement channel codes
`define LSPT_CH_PROX1 3'h0
`define LSPT_CH_PROX2 3'h1
`define LSPT_CH_PROX3 3'h2
`define LSPT_CH_VIS 3'h3
`define LSPT_CH_IR 3'h4
`define LSPT_CH_AUX 3'h5
`define LSPT_CH_UV 3'h6

// Conversion widths
`define LSPT_CONV_W 17
`define LSPT_RES_W 16

`endif

// *** rtl/lspt_param_table.v ***
// Purpose: indirect parameter table with measurement snapshot
// Assumes: command logic and sequencer share clk_sys
// Notes: entries reachable only through the command port
`include "lspt_map.vh"

module lspt_param_table (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Parameter command port
	input wire cmd_valid,
	input wire cmd_write,
	input wire [7:0] cmd_offset,
	input wire [`LSPT_DW-1:0] cmd_wdata,
	output reg cmd_done,
	output reg [`LSPT_DW-1:0] cmd_rdata,
	// Address commit
	input wire address_commit_command,
	output reg [`LSPT_DW-1:0] bus_addr_active,
	// Measurement start from the sequencer
	input wire meas_start,
	input wire [2:0] meas_chan,
	output reg meas_go,
	output reg meas_skip,
	output reg [2:0] meas_led_drive,
	output reg meas_low_align,
	// Conversion in
	input wire conv_valid,
	input wire [`LSPT_CONV_W-1:0] conv_data,
	// Aligned result out
	output reg result_valid,
	output reg [2:0] result_chan,
	output reg [`LSPT_DW-1:0] result_high,
	output reg [`LSPT_DW-1:0] result_low
);

	// Writable bits of each entry, zero for unmapped slots
	function [`LSPT_DW-1:0] entry_mask;
		input [`LSPT_IW-1:0] idx;
		begin
			case (idx)
				`LSPT_OFS_BUS_ADDR: entry_mask = `LSPT_MSK_BUS_ADDR;
				`LSPT_OFS_CHAN_EN: entry_mask = `LSPT_MSK_CHAN_EN;
				`LSPT_OFS_LED_12: entry_mask = `LSPT_MSK_LED_12;
				`LSPT_OFS_LED_3: entry_mask = `LSPT_MSK_LED_3;
				`LSPT_OFS_PROX_ALIGN: entry_mask = `LSPT_MSK_PROX_ALIGN;
				`LSPT_OFS_AMB_ALIGN: entry_mask = `LSPT_MSK_AMB_ALIGN;
				`LSPT_OFS_LED_RECOVERY_TIME: entry_mask = `LSPT_MSK_LED_RECOVERY_TIME;
				`LSPT_OFS_IR_COUNT: entry_mask = `LSPT_MSK_IR_COUNT;
				`LSPT_OFS_IR_GAIN: entry_mask = `LSPT_MSK_IR_GAIN;
				`LSPT_OFS_IR_MISC: entry_mask = `LSPT_MSK_IR_MISC;
				default: entry_mask = `LSPT_MSK_NONE;
			endcase
		end
	endfunction

	// Reset value of each entry
	function [`LSPT_DW-1:0] entry_reset;
		input [`LSPT_IW-1:0] idx;
		begin
			case (idx)
				`LSPT_OFS_LED_12: entry_reset = `LSPT_RST_LED_12;
				default: entry_reset = `LSPT_RST_ZERO;
			endcase
		end
	endfunction

	// Table storage, one byte per index
	reg [`LSPT_DW-1:0] param_mem [0:`LSPT_DEPTH-1];

	// Offset beyond the table
	wire offset_high;
	// Index into the table
	wire [`LSPT_IW-1:0] cmd_idx;
	// Write strobe for this cycle
	wire table_write;

	assign offset_high = |cmd_offset[7:`LSPT_IW];
	assign cmd_idx = cmd_offset[`LSPT_IW-1:0];
	assign table_write = cmd_valid & cmd_write & ~offset_high;

	// One clocked process per entry, masked writes keep reserved zero
	genvar g;
	generate
		for (g = 0; g < `LSPT_DEPTH; g = g + 1) begin : g_entry
			// Constant mask and reset of this slot
			localparam integer GIDX = g;
			localparam [`LSPT_IW-1:0] IDX = GIDX[`LSPT_IW-1:0];
			localparam [`LSPT_DW-1:0] MSK = entry_mask(IDX);
			localparam [`LSPT_DW-1:0] RST = entry_reset(IDX);
			always @(posedge clk_sys) begin
				if (!rst_b) begin
					param_mem[g] <= RST & MSK;
				end else if (table_write && (cmd_idx == IDX)) begin
					param_mem[g] <= cmd_wdata & MSK;
				end
			end
		end
	endgenerate

	// Read value for the command, zero outside the table
	reg [`LSPT_DW-1:0] next_rdata;

	always @* begin
		if (offset_high) begin
			next_rdata = `LSPT_RST_ZERO;
		end else if (cmd_write) begin
			// Write answers with what was kept
			next_rdata = cmd_wdata & entry_mask(cmd_idx);
		end else begin
			next_rdata = param_mem[cmd_idx];
		end
	end

	// Command answer, one cycle after the request
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			cmd_done <= 1'b0;
			cmd_rdata <= `LSPT_RST_ZERO;
		end else begin
			cmd_done <= cmd_valid;
			if (cmd_valid) begin
				cmd_rdata <= next_rdata;
			end
		end
	end

	// Active bus address follows the table only on commit
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			bus_addr_active <= `LSPT_BOOT_ADDR;
		end else if (address_commit_command) begin
			bus_addr_active <= param_mem[`LSPT_OFS_BUS_ADDR];
		end
	end

	// Named views of the table
	wire [`LSPT_DW-1:0] chan_enable_list;
	wire [`LSPT_DW-1:0] led_first_second;
	wire [`LSPT_DW-1:0] led_third;
	wire [`LSPT_DW-1:0] prox_align;
	wire [`LSPT_DW-1:0] amb_align;

	assign chan_enable_list = param_mem[`LSPT_OFS_CHAN_EN];
	assign led_first_second = param_mem[`LSPT_OFS_LED_12];
	assign led_third = param_mem[`LSPT_OFS_LED_3];
	assign prox_align = param_mem[`LSPT_OFS_PROX_ALIGN];
	assign amb_align = param_mem[`LSPT_OFS_AMB_ALIGN];

	// Channel enables by meaning
	wire uv_index_enable;
	wire auxiliary_enable;
	wire ambient_infrared_enable;
	wire ambient_visible_enable;
	wire proximity_one_enable;
	wire proximity_two_enable;
	wire proximity_three_enable;

	assign uv_index_enable = chan_enable_list[`LSPT_UV_INDEX_ENABLE];
	assign auxiliary_enable = chan_enable_list[`LSPT_EN_AUX];
	assign ambient_infrared_enable = chan_enable_list[`LSPT_EN_IR];
	assign ambient_visible_enable = chan_enable_list[`LSPT_EN_VIS];
	assign proximity_one_enable = chan_enable_list[`LSPT_EN_PROX1];
	assign proximity_two_enable = chan_enable_list[`LSPT_EN_PROX2];
	assign proximity_three_enable = chan_enable_list[`LSPT_EN_PROX3];

	// Driver masks per proximity measurement
	wire [2:0] proximity_one_driver_mask;
	wire [2:0] proximity_two_driver_mask;
	wire [2:0] proximity_three_driver_mask;

	assign proximity_one_driver_mask = led_first_second[`LSPT_LED_LO];
	assign proximity_two_driver_mask = led_first_second[`LSPT_LED_HI];
	assign proximity_three_driver_mask = led_third[`LSPT_LED_LO];

	// Alignment flags by meaning
	wire proximity_one_low_align;
	wire proximity_two_low_align;
	wire proximity_three_low_align;
	wire ambient_infrared_low_align;
	wire ambient_visible_low_align;

	assign proximity_one_low_align = prox_align[`LSPT_AL_PROX1];
	assign proximity_two_low_align = prox_align[`LSPT_AL_PROX2];
	assign proximity_three_low_align = prox_align[`LSPT_AL_PROX3];
	assign ambient_infrared_low_align = amb_align[`LSPT_AL_IR];
	assign ambient_visible_low_align = amb_align[`LSPT_AL_VIS];

	// Per-channel decode of enable, drive and alignment
	reg next_enabled;
	reg [2:0] next_drive;
	reg next_align;

	always @* begin
		next_enabled = 1'b0;
		next_drive = `LSPT_LED_NONE;
		next_align = 1'b0;
		case (meas_chan)
			`LSPT_CH_PROX1: begin
				next_enabled = proximity_one_enable;
				next_drive = proximity_one_driver_mask;
				next_align = proximity_one_low_align;
			end
			`LSPT_CH_PROX2: begin
				next_enabled = proximity_two_enable;
				next_drive = proximity_two_driver_mask;
				next_align = proximity_two_low_align;
			end
			`LSPT_CH_PROX3: begin
				next_enabled = proximity_three_enable;
				next_drive = proximity_three_driver_mask;
				next_align = proximity_three_low_align;
			end
			`LSPT_CH_VIS: begin
				next_enabled = ambient_visible_enable;
				next_align = ambient_visible_low_align;
			end
			`LSPT_CH_IR: begin
				next_enabled = ambient_infrared_enable;
				next_align = ambient_infrared_low_align;
			end
			`LSPT_CH_AUX: begin
				// No flag, upper sixteen reported
				next_enabled = auxiliary_enable;
			end
			`LSPT_CH_UV: begin
				next_enabled = uv_index_enable;
			end
			default: begin
				// Unused code is never measured
				next_enabled = 1'b0;
			end
		endcase
	end

	// Measurement in progress, waits for its conversion
	reg meas_busy;
	// Channel held for the running measurement
	reg [2:0] busy_chan;

	// Snapshot at start so host writes cannot disturb a measurement
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			meas_go <= 1'b0;
			meas_skip <= 1'b0;
			meas_led_drive <= `LSPT_LED_NONE;
			meas_low_align <= 1'b0;
			meas_busy <= 1'b0;
			busy_chan <= `LSPT_CH_PROX1;
		end else begin
			meas_go <= 1'b0;
			meas_skip <= 1'b0;
			if (meas_start && !meas_busy) begin
				// Sampled settings
				meas_go <= next_enabled;
				meas_skip <= ~next_enabled;
				meas_busy <= next_enabled;
				busy_chan <= meas_chan;
				if (next_enabled) begin
					meas_led_drive <= next_drive;
					meas_low_align <= next_align;
				end
			end else if (meas_busy && conv_valid) begin
				// Drivers off once conversion is in
				meas_busy <= 1'b0;
				meas_led_drive <= `LSPT_LED_NONE;
			end
		end
	end

	// Sixteen bits picked by the sampled flag
	wire [`LSPT_RES_W-1:0] aligned_word;

	lspt_align u_align (
		.conv_data(conv_data),
		.low_align(meas_low_align),
		.aligned_word(aligned_word)
	);

	// Result bytes for the result registers of the channel
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			result_valid <= 1'b0;
			result_chan <= `LSPT_CH_PROX1;
			result_high <= `LSPT_RST_ZERO;
			result_low <= `LSPT_RST_ZERO;
		end else begin
			result_valid <= meas_busy & conv_valid;
			if (meas_busy && conv_valid) begin
				// Aux and UV share the auxiliary bytes by channel code
				result_chan <= busy_chan;
				result_high <= aligned_word[`LSPT_RES_W-1:`LSPT_DW];
				result_low <= aligned_word[`LSPT_DW-1:0];
			end
		end
	end

endmodule // lspt_param_table

// *** verif/lspt_checker.sv ***
// Purpose: port checks for the parameter table
// Assumes: one clock, sync active-low reset
// Notes: bound to every table instance
module lspt_checker (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Command and commit
	input wire cmd_valid,
	input wire cmd_done,
	input wire address_commit_command,
	input wire [7:0] bus_addr_active,
	// Measurement
	input wire meas_start,
	input wire meas_go,
	input wire meas_skip,
	input wire [2:0] meas_led_drive,
	input wire meas_low_align,
	input wire conv_valid,
	input wire [16:0] conv_data,
	input wire result_valid,
	input wire [7:0] result_high,
	input wire [7:0] result_low
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic busy; // Measurement in flight
	// Go seen, result not yet
	always_ff @(posedge clk_sys) begin
		if (!rst_b) busy <= 1'b0;
		else if (meas_go) busy <= 1'b1;
		else if (result_valid) busy <= 1'b0;
	end
	sequence s_conv_taken;
		(busy || meas_go) && conv_valid;
	endsequence
	sequence s_result_dark;
		result_valid && meas_led_drive == 3'h0;
	endsequence
	a_cmd_answer: assert property (cmd_valid |=> cmd_done) else $error("no answer");
	a_answer_cause: assert property (cmd_done |-> $past(cmd_valid)) else $error("stray answer");
	a_addr_hold: assert property (!address_commit_command |=> $stable(bus_addr_active)) else $error("addr moved");
	a_start_answer: assert property (meas_start && !busy && !meas_go |=> meas_go != meas_skip)
		else $error("start unanswered");
	a_skip_dark: assert property (meas_skip |-> meas_led_drive == 3'h0) else $error("led on skip");
	a_conv_result: assert property (s_conv_taken |=> s_result_dark) else $error("no result");
	a_result_cause: assert property (result_valid |-> $past(conv_valid)) else $error("stray result");
	a_align_low: assert property (result_valid && meas_low_align
		|-> {result_high, result_low} == $past(conv_data[15:0])) else $error("low align");
	a_align_high: assert property (result_valid && !meas_low_align
		|-> {result_high, result_low} == $past(conv_data[16:1])) else $error("high align");
endmodule // lspt_checker

bind lspt_param_table lspt_checker u_lspt_checker (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
	.cmd_done(cmd_done), .address_commit_command(address_commit_command), .bus_addr_active(bus_addr_active),
	.meas_start(meas_start), .meas_go(meas_go), .meas_skip(meas_skip), .meas_led_drive(meas_led_drive),
	.meas_low_align(meas_low_align), .conv_valid(conv_valid), .conv_data(conv_data),
	.result_valid(result_valid), .result_high(result_high), .result_low(result_low));

// *** verif/lspt_host_model.sv ***
// Purpose: host issuing table read and write commands
// Assumes: answer one cycle after the request
// Notes: released lines carry inverted data
module lspt_host_model (
	// Clock
	input wire clk_sys,
	// Command port
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_offset,
	output logic [7:0] cmd_wdata,
	input wire cmd_done,
	input wire [7:0] cmd_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle, no request
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_offset = 8'h00;
		cmd_wdata = 8'h00;
	end
	// One access; table only reached this way
	task xfer(input logic w, input logic [7:0] o, input logic [7:0] d, output logic [7:0] r, output logic ok);
		begin
			@(posedge clk_sys);
			#1;
			cmd_valid = 1'b1;
			cmd_write = w;
			cmd_offset = o;
			cmd_wdata = d;
			@(posedge clk_sys);
			#1;
			ok = cmd_done;
			r = cmd_rdata;
			cmd_valid = 1'b0;
			cmd_offset = ~o;
			cmd_wdata = ~d;
		end
	endtask
endmodule // lspt_host_model

// *** verif/tb_light_sensor_param_table.sv ***
// Purpose: scenarios for the parameter table
// Assumes: full driver set fitted, all mask bits legal
// Notes: inputs change 1 ns after the edge
module tb_light_sensor_param_table;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_b, address_commit_command, meas_start, conv_valid;
	logic [2:0] meas_chan;
	logic [16:0] conv_data;
	wire cmd_valid, cmd_write, cmd_done, meas_go, meas_skip, meas_low_align, result_valid;
	wire [7:0] cmd_offset, cmd_wdata, cmd_rdata, bus_addr_active, result_high, result_low;
	wire [2:0] meas_led_drive, result_chan;
	int num_errors = 0;
	int n_checks = 0;
	localparam logic [7:0] ofs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h1C, 8'h1D, 8'h1E,
		8'h1F, 8'h20};
	localparam logic [7:0] msk [12] = '{8'hFF, 8'hF7, 8'h77, 8'h07, 8'h00, 8'h70, 8'h30, 8'hFF, 8'h70, 8'hFF,
		8'h20, 8'h00};
	lspt_host_model u_lspt_host_model (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata));
	lspt_param_table u_lspt_param_table (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
		.cmd_rdata(cmd_rdata), .address_commit_command(address_commit_command),
		.bus_addr_active(bus_addr_active), .meas_start(meas_start), .meas_chan(meas_chan), .meas_go(meas_go),
		.meas_skip(meas_skip), .meas_led_drive(meas_led_drive), .meas_low_align(meas_low_align),
		.conv_valid(conv_valid), .conv_data(conv_data), .result_valid(result_valid),
		.result_chan(result_chan), .result_high(result_high), .result_low(result_low));
	// Compare and count
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Verdict and end of run
	task close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One host access, answer strobe checked
	task acc(input logic w, input logic [7:0] o, input logic [7:0] d, output logic [7:0] r);
		logic ok;
		u_lspt_host_model.xfer(w, o, d, r, ok);
		chk("cmd_done", ok, 1'b1);
	endtask
	// Reset values, masks, reserved and unmapped places
	task t_table;
		logic [7:0] r;
		for (int i = 0; i < 12; i++) begin
			acc(1'b0, ofs[i], 8'h00, r);
			chk("reset value", r, ofs[i] == 8'h02 ? 8'h21 : 8'h00);
			acc(1'b1, ofs[i], 8'hFF, r);
			chk("write answer", r, msk[i]);
			acc(1'b0, ofs[i], 8'h00, r);
			chk("read back", r, msk[i]);
		end
	endtask
	// Stored address waits for the commit
	task t_commit;
		logic [7:0] r;
		acc(1'b1, 8'h00, 8'h5A, r);
		chk("addr before", bus_addr_active, 8'h00);
		address_commit_command = 1'b1;
		@(posedge clk_sys);
		#1;
		address_commit_command = 1'b0;
		chk("addr after", bus_addr_active, 8'h5A);
	endtask
	// Every channel code under one setting; reserved bits written zero
	task t_meas(input logic [7:0] en, l12, l3, pa, aa);
		logic [7:0] r;
		logic [2:0] c, led;
		logic al, on;
		logic [16:0] cv;
		acc(1'b1, 8'h01, en, r);
		acc(1'b1, 8'h02, l12, r);
		acc(1'b1, 8'h03, l3, r);
		acc(1'b1, 8'h05, pa, r);
		acc(1'b1, 8'h06, aa, r);
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			led = c == 3'h0 ? l12[2:0] : c == 3'h1 ? l12[6:4] : c == 3'h2 ? l3[2:0] : 3'h0;
			al = c < 3'h3 ? pa[4 + c] : c == 3'h3 ? aa[4] : c == 3'h4 ? aa[5] : 1'b0;
			on = c == 3'h7 ? 1'b0 : c < 3'h3 ? en[c] : en[c + 3'h1];
			cv = {c[0], en, l12} ^ 17'h0A5A5;
			@(posedge clk_sys);
			#1;
			meas_start = 1'b1;
			meas_chan = c;
			@(posedge clk_sys);
			#1;
			meas_start = 1'b0;
			chk("go", meas_go, on);
			chk("skip", meas_skip, !on);
			if (on) begin
				chk("led", meas_led_drive, led);
				chk("align", meas_low_align, al);
			end
			conv_valid = 1'b1;
			conv_data = cv;
			@(posedge clk_sys);
			#1;
			conv_valid = 1'b0;
			conv_data = ~cv;
			chk("result valid", result_valid, on);
			if (on) begin
				chk("result", {result_high, result_low}, al ? cv[15:0] : cv[16:1]);
				chk("channel", result_chan, c);
			end
		end
	endtask
	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Hang guard
	initial begin
		#20000;
		num_errors++;
		close_out;
	end
	// Main sequence
	initial begin
		rst_b = 1'b0;
		address_commit_command = 1'b0;
		meas_start = 1'b0;
		meas_chan = 3'h0;
		conv_valid = 1'b0;
		conv_data = 17'h00000;
		repeat (8) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		t_table;
		t_commit;
		t_meas(8'hF7, 8'h53, 8'h06, 8'h50, 8'h20);
		t_meas(8'h55, 8'h17, 8'h05, 8'h20, 8'h10);
		close_out;
	end
endmodule // tb_light_sensor_param_table
